// *** rtcm_ctl_model.sv ***
// Behavioural serial bus controller driving the clock high and low, with open-drain data
`timescale 1ns/1ps
module rtcm_ctl_model (
    input wire logic mclk,
    input wire logic sdaWire,
    output logic scl,
    output logic sdaRel
);
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic half();
        repeat (2) @(negedge mclk);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start();
        half();
        sdaRel = 1'b1;
        half();
        scl = 1'b1;
        half();
        sdaRel = 1'b0;
        half();
        scl = 1'b0;
    endtask
    // Clock then stands high until the next frame
    task automatic stop();
        half();
        sdaRel = 1'b0;
        half();
        scl = 1'b1;
        half();
        sdaRel = 1'b1;
        half();
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackSeen);
        for (int i = 7; i >= -1; i--) begin
            half();
            sdaRel = (i < 0) ? ackIn : tx[i];
            half();
            scl = 1'b1;
            half();
            half();
            if (i < 0) ackSeen = sdaWire;
            else rx[i] = sdaWire;
            scl = 1'b0;
        end
    endtask
endmodule

// *** rtcm_i2c_mem.sv ***
// Serial target engine for clock, SRAM and protected EEPROM access
`timescale 1ns/1ps
module rtcm_i2c_mem #(
    parameter int unsigned EE_WRITE_CYCLES = rtcm_pkg::EE_WRITE_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaOut,
    output logic sdaOeN,
    output logic eeBusy
);
    rtcm_mem_if memBus ();

    rtcm_mem #(
        .DEPTH(rtcm_pkg::MEM_DEPTH)
    ) u_mem (
        .mclk(mclk),
        .rst(rst),
        .bus(memBus)
    );

    function automatic logic [7:0] nextPtr(input logic [7:0] p);
        if (p == rtcm_pkg::CLOCK_LAST) begin
            nextPtr = rtcm_pkg::CLOCK_FIRST;
        end else if (p == rtcm_pkg::SRAM_LAST) begin
            nextPtr = rtcm_pkg::SRAM_FIRST;
        end else if (p[7:3] == rtcm_pkg::EE_FIRST[7:3]) begin
            nextPtr = {p[7:3], p[2:0] + 3'h1};
        end else begin
            nextPtr = p + 8'h01;
        end
    endfunction

    // Pin synchronisers and edge detection
    logic sclS1_r, sclS2_r, sclS3_r, sdaS1_r, sdaS2_r, sdaS3_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {sclS1_r, sclS2_r, sclS3_r} <= 3'h7;
            {sdaS1_r, sdaS2_r, sdaS3_r} <= 3'h7;
        end else begin
            {sclS1_r, sclS2_r, sclS3_r} <= {sclPin, sclS1_r, sclS2_r};
            {sdaS1_r, sdaS2_r, sdaS3_r} <= {sdaPin, sdaS1_r, sdaS2_r};
        end
    end
    wire sclRise = sclS2_r & ~sclS3_r;
    wire sclFall = ~sclS2_r & sclS3_r;
    wire startDet = sclS2_r & sclS3_r & ~sdaS2_r & sdaS3_r;
    wire stopDet = sclS2_r & sclS3_r & sdaS2_r & ~sdaS3_r;
    wire sdaIn = sdaS2_r;

    rtcm_pkg::rtcm_state_t state_r, state_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] rxSh_r, rxSh_nxt, txSh_r, txSh_nxt, ptr_r, ptr_nxt;
    logic sdaOeN_r, sdaOeN_nxt, eeSpace_r, eeSpace_nxt, rdMode_r, rdMode_nxt;
    logic eeWrote_r, eeWrote_nxt, commitReq_r, eeBusy_r;
    logic [1:0] lock_r, lock_nxt;
    logic [31:0] busyCnt_r, busyCnt_nxt;
    logic [3:0] commitIdx_r, commitIdx_nxt;
    logic [7:0] pageData_r [rtcm_pkg::EE_BYTES];
    logic [rtcm_pkg::EE_BYTES-1:0] pageMask_r;

    // Decoding of received bytes and pointer
    wire rxDone = sclFall && (bitCnt_r == rtcm_pkg::BIT_LAST);
    wire busy = (busyCnt_r != 32'h0);
    wire ctrlIsClock = (rxSh_r[7:1] == rtcm_pkg::CTRL_CLOCK_SRAM);
    wire ctrlIsEe = (rxSh_r[7:1] == rtcm_pkg::CTRL_EEPROM);
    wire ctrlOk = ctrlIsClock | (ctrlIsEe & ~busy);
    wire rxInEe = (rxSh_r >= rtcm_pkg::EE_FIRST) && (rxSh_r <= rtcm_pkg::EE_LAST);
    wire rxInClock = (rxSh_r <= rtcm_pkg::SRAM_LAST);
    wire addrOk = eeSpace_r ? rxInEe : rxInClock;
    wire [7:0] ptrNext = nextPtr(ptr_r);
    wire ptrInEe = (ptr_r[7:3] == rtcm_pkg::EE_FIRST[7:3]);
    wire ptrInClock = (ptr_r <= rtcm_pkg::SRAM_LAST);
    wire ptrIsKey = (ptr_r == rtcm_pkg::UNLOCK_KEY_ADDR);
    wire [6:0] ptrIdx = ptrInEe ? (rtcm_pkg::EE_BASE_IDX | {4'h0, ptr_r[2:0]}) : ptr_r[6:0];
    // Key location and unmapped pointer read as zero
    wire [7:0] readByte = ((ptrInClock && !ptrIsKey) || ptrInEe) ? memBus.rdata : 8'h00;

    // Two-entry write buffer: {eeprom, address, data}
    logic [16:0] fifoMem_r [2];
    logic fifoWr_r, fifoRd_r;
    logic [1:0] fifoCnt_r;
    wire fifoInReady = (fifoCnt_r != 2'h2);
    wire fifoOutValid = (fifoCnt_r != 2'h0);
    wire commitActive = (commitIdx_r != rtcm_pkg::COMMIT_IDLE);
    wire fifoOutReady = ~commitActive;
    wire pushReq = (state_r == rtcm_pkg::ST_WDATA) && rxDone && fifoInReady && !startDet && !stopDet;
    wire pop = fifoOutValid & fifoOutReady;
    wire [16:0] pushItem = {eeSpace_r, ptr_r, rxSh_r};
    wire [16:0] popItem = fifoMem_r[fifoRd_r];
    wire itEe = popItem[16];
    wire [7:0] itAddr = popItem[15:8];
    wire [7:0] itData = popItem[7:0];
    wire itKey = !itEe && (itAddr == rtcm_pkg::UNLOCK_KEY_ADDR);
    wire [1:0] fifoCnt_nxt = fifoCnt_r + {1'b0, pushReq} - {1'b0, pop};

    // Unlock progress and EEPROM commit
    wire keyStep1 = (lock_r == rtcm_pkg::LOCK_IDLE) && (itData == rtcm_pkg::UNLOCK_KEY1);
    wire keyStep2 = (lock_r == rtcm_pkg::LOCK_KEY1) && (itData == rtcm_pkg::UNLOCK_KEY2);
    wire [1:0] lockKey = keyStep1 ? rtcm_pkg::LOCK_KEY1 : (keyStep2 ? rtcm_pkg::LOCK_OPEN : rtcm_pkg::LOCK_IDLE);
    wire commitGo = commitReq_r && !fifoOutValid && !busy;
    wire commitStart = commitGo && (pageMask_r != '0);
    wire pageWr = pop && itEe && (lock_r == rtcm_pkg::LOCK_OPEN);
    wire commitDone = commitActive && (commitIdx_r[2:0] == 3'h7);
    wire commitSet = (startDet | stopDet) & eeWrote_r;

    always_comb begin
        lock_nxt = lock_r;
        if (commitGo) begin
            lock_nxt = rtcm_pkg::LOCK_IDLE;
        end else if (pop && !itEe) begin
            lock_nxt = itKey ? lockKey : rtcm_pkg::LOCK_IDLE;
        end
    end

    assign busyCnt_nxt = commitStart ? 32'(EE_WRITE_CYCLES) : (busy ? busyCnt_r - 32'h1 : 32'h0);
    assign commitIdx_nxt = commitStart ? 4'h0 : (commitDone ? rtcm_pkg::COMMIT_IDLE :
                           (commitActive ? commitIdx_r + 4'h1 : commitIdx_r));

    // Commit walk owns the write port; the buffer stalls meanwhile
    wire [2:0] ci = commitIdx_r[2:0];
    wire drainWe = pop && !itEe && !itKey && (itAddr <= rtcm_pkg::SRAM_LAST);
    assign memBus.we = commitActive ? pageMask_r[ci] : drainWe;
    assign memBus.waddr = commitActive ? (rtcm_pkg::EE_BASE_IDX | {4'h0, ci}) : itAddr[6:0];
    assign memBus.wdata = commitActive ? pageData_r[ci] : itData;
    assign memBus.raddr = ptrIdx;

    // Bus protocol
    always_comb begin
        state_nxt = state_r;
        bitCnt_nxt = bitCnt_r;
        rxSh_nxt = rxSh_r;
        txSh_nxt = txSh_r;
        sdaOeN_nxt = sdaOeN_r;
        ptr_nxt = ptr_r;
        eeSpace_nxt = eeSpace_r;
        rdMode_nxt = rdMode_r;
        eeWrote_nxt = eeWrote_r;
        if (startDet || stopDet) begin
            state_nxt = startDet ? rtcm_pkg::ST_CTRL : rtcm_pkg::ST_IDLE;
            bitCnt_nxt = 4'h0;
            sdaOeN_nxt = 1'b1;
            eeWrote_nxt = 1'b0;
        end else begin
            case (state_r)
                rtcm_pkg::ST_CTRL, rtcm_pkg::ST_ADDR, rtcm_pkg::ST_WDATA: begin
                    if (sclRise && bitCnt_r != rtcm_pkg::BIT_LAST) begin
                        rxSh_nxt = {rxSh_r[6:0], sdaIn};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end else if (rxDone) begin
                        if (state_r == rtcm_pkg::ST_CTRL) begin
                            state_nxt = ctrlOk ? rtcm_pkg::ST_CTRL_ACK : rtcm_pkg::ST_WAIT;
                            sdaOeN_nxt = ~ctrlOk;
                            eeSpace_nxt = ctrlIsEe;
                            rdMode_nxt = rxSh_r[0];
                        end else if (state_r == rtcm_pkg::ST_ADDR) begin
                            state_nxt = addrOk ? rtcm_pkg::ST_ADDR_ACK : rtcm_pkg::ST_WAIT;
                            sdaOeN_nxt = ~addrOk;
                            ptr_nxt = addrOk ? rxSh_r : ptr_r;
                        end else begin
                            state_nxt = fifoInReady ? rtcm_pkg::ST_WDATA_ACK : rtcm_pkg::ST_WAIT;
                            sdaOeN_nxt = ~fifoInReady;
                            ptr_nxt = fifoInReady ? ptrNext : ptr_r;
                            eeWrote_nxt = eeWrote_r | (fifoInReady & eeSpace_r);
                        end
                    end
                end
                rtcm_pkg::ST_CTRL_ACK: begin
                    if (sclFall) begin
                        bitCnt_nxt = rdMode_r ? 4'h1 : 4'h0;
                        state_nxt = rdMode_r ? rtcm_pkg::ST_RDATA : rtcm_pkg::ST_ADDR;
                        txSh_nxt = readByte;
                        sdaOeN_nxt = rdMode_r ? readByte[7] : 1'b1;
                    end
                end
                rtcm_pkg::ST_ADDR_ACK, rtcm_pkg::ST_WDATA_ACK: begin
                    if (sclFall) begin
                        bitCnt_nxt = 4'h0;
                        state_nxt = rtcm_pkg::ST_WDATA;
                        sdaOeN_nxt = 1'b1;
                    end
                end
                rtcm_pkg::ST_RDATA: begin
                    if (sclFall && bitCnt_r == rtcm_pkg::BIT_LAST) begin
                        state_nxt = rtcm_pkg::ST_RACK;
                        sdaOeN_nxt = 1'b1;
                    end else if (sclFall) begin
                        txSh_nxt = {txSh_r[6:0], 1'b0};
                        sdaOeN_nxt = txSh_r[6];
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end
                end
                rtcm_pkg::ST_RACK: begin
                    // Pointer moves past the sent byte whether or not it was acknowledged
                    if (sclRise) begin
                        ptr_nxt = ptrNext;
                        state_nxt = sdaIn ? rtcm_pkg::ST_WAIT : rtcm_pkg::ST_CTRL_ACK;
                    end
                end
                rtcm_pkg::ST_IDLE, rtcm_pkg::ST_WAIT: begin
                    state_nxt = state_r;
                end
                default: begin
                    state_nxt = rtcm_pkg::ST_IDLE;
                    sdaOeN_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= rtcm_pkg::ST_IDLE;
            bitCnt_r <= 4'h0;
            rxSh_r <= 8'h00;
            txSh_r <= 8'h00;
            sdaOeN_r <= 1'b1;
            ptr_r <= rtcm_pkg::PTR_RESET;
            eeSpace_r <= 1'b0;
            rdMode_r <= 1'b0;
            eeWrote_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
            rxSh_r <= rxSh_nxt;
            txSh_r <= txSh_nxt;
            sdaOeN_r <= sdaOeN_nxt;
            ptr_r <= ptr_nxt;
            eeSpace_r <= eeSpace_nxt;
            rdMode_r <= rdMode_nxt;
            eeWrote_r <= eeWrote_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fifoMem_r[0] <= 17'h0;
            fifoMem_r[1] <= 17'h0;
            fifoWr_r <= 1'b0;
            fifoRd_r <= 1'b0;
            fifoCnt_r <= 2'h0;
        end else begin
            if (pushReq) begin
                fifoMem_r[fifoWr_r] <= pushItem;
                fifoWr_r <= ~fifoWr_r;
            end
            fifoRd_r <= fifoRd_r ^ pop;
            fifoCnt_r <= fifoCnt_nxt;
        end
    end

    // A commit request raised as the previous one is taken is kept
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            commitReq_r <= 1'b0;
            lock_r <= rtcm_pkg::LOCK_IDLE;
            busyCnt_r <= 32'h0;
            eeBusy_r <= 1'b0;
            commitIdx_r <= rtcm_pkg::COMMIT_IDLE;
        end else begin
            commitReq_r <= commitSet | (commitReq_r & ~commitGo);
            lock_r <= lock_nxt;
            busyCnt_r <= busyCnt_nxt;
            eeBusy_r <= (busyCnt_nxt != 32'h0);
            commitIdx_r <= commitIdx_nxt;
        end
    end

    for (genvar i = 0; i < rtcm_pkg::EE_BYTES; i++) begin : g_page
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                pageData_r[i] <= 8'h00;
                pageMask_r[i] <= 1'b0;
            end else if (pageWr && itAddr[2:0] == 3'(i)) begin
                pageData_r[i] <= itData;
                pageMask_r[i] <= 1'b1;
            end else if (commitDone) begin
                pageMask_r[i] <= 1'b0;
            end
        end
    end

    // Open drain: data output is always low, enable carries the bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end
    assign sdaOeN = sdaOeN_r;
    assign eeBusy = eeBusy_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    wire ctrlDecide = (state_r == rtcm_pkg::ST_CTRL) && rxDone && !startDet && !stopDet;
    wire addrDecide = (state_r == rtcm_pkg::ST_ADDR) && rxDone && !startDet && !stopDet;
    wire rackSample = (state_r == rtcm_pkg::ST_RACK) && sclRise && !startDet && !stopDet;

    sequence keyFinal;
        pop && itKey && (lock_r == rtcm_pkg::LOCK_KEY1) && (itData == rtcm_pkg::UNLOCK_KEY2);
    endsequence
    sequence keyWrong;
        pop && itKey && (lock_r == rtcm_pkg::LOCK_KEY1) && (itData != rtcm_pkg::UNLOCK_KEY2) && !commitGo;
    endsequence

    clock_wrap_a: assert property (rackSample && ptr_r == rtcm_pkg::CLOCK_LAST |=> ptr_r == 8'h00)
        else $error("clock block pointer did not wrap to zero");
    sram_wrap_a: assert property (rackSample && ptr_r == rtcm_pkg::SRAM_LAST |=> ptr_r == 8'h20)
        else $error("SRAM pointer did not wrap to first SRAM byte");
    ee_wrap_a: assert property (rackSample && ptr_r == rtcm_pkg::EE_LAST |=> ptr_r == 8'hf0)
        else $error("EEPROM pointer did not wrap to first location");
    read_advance_a: assert property (rackSample |=> ptr_r == $past(ptrNext))
        else $error("pointer not advanced after a read byte");
    key_read_zero_a: assert property ((state_r == rtcm_pkg::ST_CTRL_ACK) && sclFall && rdMode_r
        && ptrIsKey && !startDet && !stopDet |=> txSh_r == 8'h00 && !sdaOeN_r)
        else $error("unlock key location did not read as zero");
    ee_busy_nack_a: assert property (ctrlDecide && ctrlIsEe && busy |=> sdaOeN_r
        && state_r == rtcm_pkg::ST_WAIT)
        else $error("EEPROM command acknowledged during write cycle");
    clock_busy_ack_a: assert property (ctrlDecide && ctrlIsClock |=> (!sdaOeN_r)[*2])
        else $error("clock or SRAM command refused");
    ee_read_ack_a: assert property (ctrlDecide && ctrlIsEe && !busy && rxSh_r[0] |=> !sdaOeN_r)
        else $error("EEPROM read refused while idle");
    ee_range_nack_a: assert property (addrDecide && eeSpace_r && !rxInEe |=> sdaOeN_r
        && ptr_r == $past(ptr_r))
        else $error("out of range EEPROM address acknowledged");
    busy_hold_a: assert property (commitStart |=> busy[*8])
        else $error("write cycle ended early");
    relock_a: assert property (commitGo |=> lock_r == rtcm_pkg::LOCK_IDLE)
        else $error("EEPROM stayed unlocked after a write");
    key_open_a: assert property (keyFinal |=> lock_r == rtcm_pkg::LOCK_OPEN)
        else $error("correct key sequence did not unlock");
    key_wrong_a: assert property (keyWrong |=> lock_r == rtcm_pkg::LOCK_IDLE)
        else $error("wrong second key left the unlock open");
    page_after_stop_a: assert property (memBus.we && memBus.waddr >= rtcm_pkg::EE_BASE_IDX
        |-> commitActive && busy)
        else $error("EEPROM written outside a commit");
endmodule

// *** rtcm_i2c_mem_bench.sv ***
// Self-checking bench for the serial memory access engine
`timescale 1ns/1ps
module rtcm_i2c_mem_bench;
    localparam int WC = 600;
    localparam logic [6:0] CS = rtcm_pkg::CTRL_CLOCK_SRAM;
    localparam logic [6:0] EE = rtcm_pkg::CTRL_EEPROM;
    logic mclk, rst, scl, sdaRel, sdaOut, sdaOeN, eeBusy, sdaWire, ack;
    logic [7:0] expMem [256];
    logic [7:0] wBuf [9];
    logic [7:0] rx;
    int errors, cmp_count;
    // Pulled-up wire: low if either party pulls
    assign sdaWire = sdaRel & (sdaOeN | sdaOut);
    rtcm_i2c_mem #(.EE_WRITE_CYCLES(WC)) i_dut (.mclk(mclk), .rst(rst), .sclPin(scl), .sdaPin(sdaWire),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .eeBusy(eeBusy));
    rtcm_ctl_model i_ctl (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaRel(sdaRel));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] nextA(input logic [7:0] a);
        if (a == 8'h1f) return 8'h00;
        if (a == 8'h5f) return 8'h20;
        if (a[7:3] == 5'h1e) return {a[7:3], a[2:0] + 3'h1};
        return a + 8'h01;
    endfunction
    task automatic wr(input logic [6:0] c, input logic [7:0] a, input int n);
        logic a0;
        i_ctl.start();
        i_ctl.xfer({c, 1'b0}, 1'b1, rx, a0);
        chk("control ack", {7'h0, a0}, 8'h00);
        i_ctl.xfer(a, 1'b1, rx, ack);
        for (int i = 0; i < n; i++) i_ctl.xfer(wBuf[i], 1'b1, rx, a0);
        i_ctl.stop();
    endtask
    // Pointer follows the read so later current reads can be checked
    task automatic rd(input logic [6:0] c, inout logic [7:0] a, input int n, input logic setA);
        logic a0;
        if (setA) begin
            i_ctl.start();
            i_ctl.xfer({c, 1'b0}, 1'b1, rx, a0);
            i_ctl.xfer(a, 1'b1, rx, a0);
        end
        i_ctl.start();
        i_ctl.xfer({c, 1'b1}, 1'b1, rx, a0);
        for (int i = 0; i < n; i++) begin
            i_ctl.xfer(8'hff, (i == n - 1), rx, a0);
            chk("read byte", rx, expMem[a]);
            a = nextA(a);
        end
        chk("data level", {7'h0, sdaOut}, 8'h00);
        i_ctl.stop();
    endtask
    task automatic poll(output logic a0);
        i_ctl.start();
        i_ctl.xfer({EE, 1'b0}, 1'b1, rx, a0);
        i_ctl.stop();
    endtask
    task automatic idle();
        logic a0 = 1'b1;
        for (int k = 0; k < 20 && a0; k++) poll(a0);
        chk("poll done", {7'h0, a0}, 8'h00);
    endtask
    task automatic eeWr(inout logic [7:0] a, input int n, input logic open);
        logic a0;
        if (open) begin
            wBuf[0] = rtcm_pkg::UNLOCK_KEY1;
            wr(CS, rtcm_pkg::UNLOCK_KEY_ADDR, 1);
            wBuf[0] = rtcm_pkg::UNLOCK_KEY2;
            wr(CS, rtcm_pkg::UNLOCK_KEY_ADDR, 1);
        end
        for (int i = 0; i < n; i++) wBuf[i] = 8'($urandom);
        wr(EE, a, n);
        for (int i = 0; i < n; i++) begin
            if (open) expMem[a] = wBuf[i];
            a = nextA(a);
        end
        repeat (6) @(negedge mclk);
        chk("write busy", {7'h0, eeBusy}, {7'h0, open});
        poll(a0);
        chk("busy poll", {7'h0, a0}, {7'h0, open});
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        #3000000;
        errors++;
        summarize();
    end
    initial begin
        logic [7:0] a, p;
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        void'($urandom(34276));
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        // Both block ends, then a random SRAM spot
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? 8'h1e : (k == 1) ? 8'h5e : 8'h20 + 8'($urandom % 60);
            p = a;
            for (int i = 0; i < 4; i++) begin
                wBuf[i] = 8'($urandom);
                expMem[p] = wBuf[i];
                p = nextA(p);
            end
            wr(CS, a, 4);
            rd(CS, a, 3, 1'b1);
            rd(CS, a, 1, 1'b0);
        end
        wBuf[0] = 8'h37;
        wr(CS, rtcm_pkg::UNLOCK_KEY_ADDR, 1);
        expMem[rtcm_pkg::UNLOCK_KEY_ADDR] = 8'h00;
        a = rtcm_pkg::UNLOCK_KEY_ADDR;
        rd(CS, a, 1, 1'b1);
        // Nine page bytes wrap over the first one
        a = 8'hf0;
        eeWr(a, 9, 1'b1);
        p = 8'h5e;
        rd(CS, p, 1, 1'b1);
        idle();
        a = 8'hf6;
        rd(EE, a, 4, 1'b1);
        a = 8'hf3;
        eeWr(a, 1, 1'b1);
        idle();
        rd(EE, a, 1, 1'b0);
        wBuf[0] = rtcm_pkg::UNLOCK_KEY1;
        wr(CS, rtcm_pkg::UNLOCK_KEY_ADDR, 1);
        wBuf[0] = 8'h37;
        wr(CS, rtcm_pkg::UNLOCK_KEY_ADDR, 1);
        a = 8'hf2;
        eeWr(a, 2, 1'b0);
        a = 8'hf2;
        rd(EE, a, 2, 1'b1);
        for (int k = 0; k < 2; k++) begin
            wr(EE, k ? 8'hf8 : 8'hef, 1);
            chk("range ack", {7'h0, ack}, 8'h01);
            poll(ack);
            chk("ready at once", {7'h0, ack}, 8'h00);
            idle();
        end
        wr(CS, 8'h60, 1);
        chk("clock range ack", {7'h0, ack}, 8'h01);
        summarize();
    end
endmodule

// *** rtcm_mem.sv ***
// Byte memory for clock registers, SRAM and EEPROM with registered read
`timescale 1ns/1ps
module rtcm_mem #(
    parameter int DEPTH = rtcm_pkg::MEM_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    rtcm_mem_if.mem bus
);
    logic [7:0] store [DEPTH];
    logic [7:0] rdata_r;

    // Contents are not reset, like battery-backed storage
    always_ff @(posedge mclk) begin
        if (bus.we) begin
            store[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= store[bus.raddr];
        end
    end

    assign bus.rdata = rdata_r;
endmodule

// *** rtcm_mem_if.sv ***
// Port bundle between the access engine and its byte memory
`timescale 1ns/1ps
interface rtcm_mem_if;
    logic we;
    logic [rtcm_pkg::MEM_AW-1:0] waddr;
    logic [7:0] wdata;
    logic [rtcm_pkg::MEM_AW-1:0] raddr;
    logic [7:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** rtcm_pkg.sv ***
// Shared constants and types for the serial memory access engine
package rtcm_pkg;
    // Seven-bit target codes, read/write bit excluded
    localparam logic [6:0] CTRL_CLOCK_SRAM = 7'h6f;
    localparam logic [6:0] CTRL_EEPROM = 7'h57;
    // Address map of the shared pointer
    localparam logic [7:0] CLOCK_FIRST = 8'h00;
    localparam logic [7:0] CLOCK_LAST = 8'h1f;
    localparam logic [7:0] SRAM_FIRST = 8'h20;
    localparam logic [7:0] SRAM_LAST = 8'h5f;
    localparam logic [7:0] EE_FIRST = 8'hf0;
    localparam logic [7:0] EE_LAST = 8'hf7;
    localparam logic [7:0] UNLOCK_KEY_ADDR = 8'h0f;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // Memory layout: clock regs and SRAM at 0..95, EEPROM after them
    localparam int MEM_AW = 7;
    localparam int MEM_DEPTH = 104;
    localparam logic [6:0] EE_BASE_IDX = 7'h60;
    localparam int EE_BYTES = 8;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] COMMIT_IDLE = 4'h8;
    localparam int EE_WRITE_CYCLES_DEF = 100000;
    // Unlock progress
    localparam logic [1:0] LOCK_IDLE = 2'h0;
    localparam logic [1:0] LOCK_KEY1 = 2'h1;
    localparam logic [1:0] LOCK_OPEN = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CTRL = 4'b0001,
        ST_CTRL_ACK = 4'b0010,
        ST_ADDR = 4'b0011,
        ST_ADDR_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK = 4'b1000,
        ST_WAIT = 4'b1001
    } rtcm_state_t;
endpackage
